// file: pkg/adc_seq_defines.vh
// constants for the converter sequencer: register offsets, field positions,
// reset values and timing counts; definitions only, included by bare name
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH

// register byte offsets (one aligned 32-bit word each)
`define OFS_START          8'h00
`define OFS_MODE_CONTROL_3 8'h04
`define OFS_SCAN_CFG       8'h08
`define OFS_PRIO_CFG       8'h0C
`define OFS_SAMPLE_HOLD    8'h10
`define OFS_FLAG_STATUS    8'h14
`define OFS_RESULT_BASE    8'h20
`define OFS_RESULT_LAST    8'h3C
`define OFS_PRIO_RESULT    8'h40

// start register bits (write one to start, read as zero)
`define BIT_NORMAL_START   0
`define BIT_PRIO_START     1

// mode_control_3 fields
`define BIT_REPEAT         0
`define BIT_SCAN           1
`define ITM_LSB            4
`define ITM_MSB            6
`define FIXCH_LSB          8
`define FIXCH_MSB          10

// scan configuration fields
`define SSTART_LSB         0
`define SSTART_MSB         3
`define SWIDTH_LSB         4
`define SWIDTH_MSB         7

// flag_status_reg bits
`define BIT_EOC            0
`define BIT_BUSY           1
`define BIT_HP_EOC         2
`define BIT_HP_BUSY        3

// reset values
`define MODE3_RESET        11'h000
`define SCAN_RESET         8'h00
`define PRIO_CH_RESET      3'h0

// sample-hold window in converter clock cycles, and conversion length
`define SH_MIN             9'h00A
`define SH_MAX             9'h140
`define SH_RESET           9'h00A
`define CONV_CYCLES        9'h00D

// result width and the slot index of the priority result
`define RES_W              12
`define PRIO_SLOT          4'h8

`endif

// file: logic/conv_timer.v
// sample-hold and conversion timer for one conversion at a time
// assumes the converter core drives adc_data_i steadily by the end of the
// conversion window; a new start restarts the window at once
`timescale 1ns/100ps
`include "adc_seq_defines.vh"

module conv_timer (
   input  wire                ref_clk_i,   // converter clock
   input  wire                sys_rst_i,   // synchronous, active high
   input  wire                start_i,     // begin or restart a conversion
   input  wire [2:0]          channel_i,   // input channel to convert
   input  wire [8:0]          hold_i,      // sample-hold cycles, already clamped
   input  wire [`RES_W-1:0]   adc_data_i,  // converter core result
   output reg                 sample_o,    // sample-hold switch closed
   output reg  [2:0]          channel_o,   // channel routed to the core
   output reg                 done_o,      // one-cycle pulse, data_o valid
   output reg  [`RES_W-1:0]   data_o       // captured result
);

   reg [9:0] count_r;   // cycles left in the window
   reg       run_r;     // a conversion is in progress

   ////////////////////////////////////////////////////////////////////////////
   // countdown: hold phase first, then the fixed conversion phase
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         count_r   <= 10'h000;
         run_r     <= 1'b0;
         sample_o  <= 1'b0;
         channel_o <= 3'h0;
         done_o    <= 1'b0;
         data_o    <= {`RES_W{1'b0}};
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            // restart drops any conversion in flight, its result is lost
            count_r   <= {1'b0, hold_i} + {1'b0, `CONV_CYCLES} - 10'h001;
            run_r     <= 1'b1;
            sample_o  <= 1'b1;
            channel_o <= channel_i;
         end else if (run_r) begin
            if (count_r == {1'b0, `CONV_CYCLES})
               sample_o <= 1'b0;              // hold window over
            if (count_r == 10'h000) begin
               run_r  <= 1'b0;
               done_o <= 1'b1;
               data_o <= adc_data_i;
            end else begin
               count_r <= count_r - 10'h001;
            end
         end
      end
   end

endmodule

// file: logic/result_bank.v
// result storage: eight normal slots and one priority slot
// assumes one write per cycle at most; reads are combinational
`timescale 1ns/100ps
`include "adc_seq_defines.vh"

module result_bank (
   input  wire                ref_clk_i,   // converter clock
   input  wire                sys_rst_i,   // synchronous, active high
   input  wire                wr_i,        // write strobe
   input  wire [3:0]          wr_idx_i,    // 0..7 normal, 8 priority
   input  wire [`RES_W-1:0]   wr_data_i,   // value to store
   input  wire [3:0]          rd_idx_i,    // slot to read
   output wire [`RES_W-1:0]   rd_data_o    // slot content
);

   reg [`RES_W-1:0] slot_r [0:8];   // storage array
   genvar g;

   ////////////////////////////////////////////////////////////////////////////
   // one writable slot per index
   generate
      for (g = 0; g < 9; g = g + 1) begin : gen_slot
         always @(posedge ref_clk_i) begin
            if (sys_rst_i)
               slot_r[g] <= {`RES_W{1'b0}};
            else if (wr_i && (wr_idx_i == g))
               slot_r[g] <= wr_data_i;
         end
      end
   endgenerate

   // out-of-range index reads zero
   assign rd_data_o = (rd_idx_i <= `PRIO_SLOT) ? slot_r[rd_idx_i] : {`RES_W{1'b0}};

endmodule

// file: logic/adc_conversion_sequencer.v
// converter sequencer with apb register access
// assumes the converter core runs on ref_clk_i and returns data when asked
`timescale 1ns/100ps
`include "adc_seq_defines.vh"

module adc_conversion_sequencer (
   input  wire                ref_clk_i,         // converter clock, 10 MHz
   input  wire                sys_rst_i,         // synchronous, active high
   input  wire                psel_i,            // apb select
   input  wire                penable_i,         // apb access phase
   input  wire                pwrite_i,          // apb direction
   input  wire [7:0]          paddr_i,           // apb byte address
   input  wire [31:0]         pwdata_i,          // apb write data
   output wire [31:0]         prdata_o,          // apb read data
   output wire                pready_o,          // apb ready, always high
   output wire                pslverr_o,         // apb error on unmapped
   input  wire [`RES_W-1:0]   adc_data_i,        // converter core result
   output wire                sample_o,          // sample-hold switch closed
   output wire [2:0]          channel_o,         // channel routed to the core
   output reg                 normal_done_irq_o, // one-cycle completion pulse
   output reg                 priority_done_irq_o// one-cycle completion pulse
);

   // one-hot sequencer states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_NORM = 3'b010;
   localparam [2:0] ST_PRIO = 3'b100;

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   reg  [2:0]        state_r;       // sequencer state
   reg  [10:0]       mode3_r;       // mode_control_3
   reg  [7:0]        scan_r;        // scan start and width
   reg  [2:0]        prio_ch_r;     // priority_channel_select
   reg  [8:0]        hold_r;        // sample-hold cycles
   reg               eoc_r;         // normal completion flag
   reg               busy_r;        // normal job in progress (also suspended)
   reg               hp_eoc_r;      // priority completion flag
   reg               hp_busy_r;     // priority conversion running
   reg  [2:0]        cur_ch_r;      // channel of the normal job
   reg  [2:0]        rep_idx_r;     // slot index in fixed repeat
   reg               job_rep_r;     // job started in a repeat mode
   reg               job_scan_r;    // job started in a scan mode
   reg  [2:0]        job_itm_r;     // latched group size minus one
   reg  [2:0]        job_first_r;   // latched first scan channel
   reg  [2:0]        job_last_r;    // latched last scan channel
   reg  [2:0]        state_nxt;
   reg               eoc_set;       // normal completion event
   reg               hp_eoc_set;    // priority completion event
   reg               tmr_start;     // start a conversion this cycle
   reg  [2:0]        tmr_ch;        // channel for that start
   reg               res_wr;        // result write strobe
   reg  [3:0]        res_idx;       // slot written
   wire              tmr_done;      // conversion finished
   wire [`RES_W-1:0] tmr_data;      // its result
   wire [`RES_W-1:0] bank_rd;       // slot read for the bus
   wire [2:0]        scan_first;    // clamped start channel
   wire [4:0]        scan_sum;      // start plus width
   wire [2:0]        scan_last;     // clamped last channel
   wire [8:0]        hold_eff;      // clamped sample-hold length
   wire              wr_acc;        // apb write access phase
   wire              rd_acc;        // apb read access phase
   wire              normal_go;     // software starts normal conversion
   wire              prio_go;       // software starts priority conversion
   wire              rd_flags;      // status read, clears completion flags
   wire              cont;          // repeat still enabled
   wire [3:0]        rd_slot;       // slot chosen by read address

   ////////////////////////////////////////////////////////////////////////////
   // address decode helper, used for both write and read paths
   function is_result_addr;
      input [7:0] a;
      begin
         is_result_addr = ((a >= `OFS_RESULT_BASE) && (a <= `OFS_RESULT_LAST) && (a[1:0] == 2'b00))
                          || (a == `OFS_PRIO_RESULT);
      end
   endfunction

   // true for every mapped offset
   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = (a == `OFS_START) || (a == `OFS_MODE_CONTROL_3) || (a == `OFS_SCAN_CFG)
                     || (a == `OFS_PRIO_CFG) || (a == `OFS_SAMPLE_HOLD)
                     || (a == `OFS_FLAG_STATUS) || is_result_addr(a);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // apb: zero wait states, error on unmapped offsets
   assign wr_acc    = psel_i && penable_i && pwrite_i;
   assign rd_acc    = psel_i && penable_i && !pwrite_i;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !is_mapped(paddr_i);
   assign normal_go = wr_acc && (paddr_i == `OFS_START) && pwdata_i[`BIT_NORMAL_START];
   assign prio_go   = wr_acc && (paddr_i == `OFS_START) && pwdata_i[`BIT_PRIO_START];
   assign rd_flags  = rd_acc && (paddr_i == `OFS_FLAG_STATUS);
   assign rd_slot   = (paddr_i == `OFS_PRIO_RESULT) ? `PRIO_SLOT : {1'b0, paddr_i[4:2]};

   // config registers
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         mode3_r   <= `MODE3_RESET;
         scan_r    <= `SCAN_RESET;
         prio_ch_r <= `PRIO_CH_RESET;
         hold_r    <= `SH_RESET;
      end else if (wr_acc) begin
         case (paddr_i)
            `OFS_MODE_CONTROL_3: mode3_r   <= pwdata_i[10:0];
            `OFS_SCAN_CFG:       scan_r    <= pwdata_i[7:0];
            `OFS_PRIO_CFG:       prio_ch_r <= pwdata_i[2:0];
            `OFS_SAMPLE_HOLD:    hold_r    <= pwdata_i[8:0];
            default:             hold_r    <= hold_r;
         endcase
      end
   end

   // read mux; reads of write-only start register return zero
   assign prdata_o = !rd_acc ? 32'h0000_0000 :
                     (paddr_i == `OFS_MODE_CONTROL_3) ? {21'h000000, mode3_r} :
                     (paddr_i == `OFS_SCAN_CFG)       ? {24'h000000, scan_r} :
                     (paddr_i == `OFS_PRIO_CFG)       ? {29'h00000000, prio_ch_r} :
                     (paddr_i == `OFS_SAMPLE_HOLD)    ? {23'h000000, hold_r} :
                     (paddr_i == `OFS_FLAG_STATUS)    ? {28'h0000000, hp_busy_r, hp_eoc_r, busy_r, eoc_r} :
                     is_result_addr(paddr_i)          ? {{(32-`RES_W){1'b0}}, bank_rd} :
                     32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // derived settings
   // out-of-range length is pulled to the nearest legal value
   assign hold_eff   = (hold_r < `SH_MIN) ? `SH_MIN : (hold_r > `SH_MAX) ? `SH_MAX : hold_r;
   // start code above seven is prohibited; treated as seven
   assign scan_first = (scan_r[`SSTART_MSB:`SSTART_LSB] > 4'h7) ? 3'h7 : scan_r[2:0];
   assign scan_sum   = {2'b00, scan_first} + {1'b0, scan_r[`SWIDTH_MSB:`SWIDTH_LSB]};
   assign scan_last  = (scan_sum > 5'h07) ? 3'h7 : scan_sum[2:0];
   // clearing the repeat bit lets the running conversion finish
   assign cont       = job_rep_r && mode3_r[`BIT_REPEAT];

   ////////////////////////////////////////////////////////////////////////////
   // sequencer next-state and conversion issue
   always @* begin
      state_nxt  = state_r;
      eoc_set    = 1'b0;
      hp_eoc_set = 1'b0;
      tmr_start  = 1'b0;
      tmr_ch     = cur_ch_r;
      res_wr     = 1'b0;
      res_idx    = {1'b0, cur_ch_r};
      case (state_r)
         ST_IDLE: begin
            if (prio_go) begin
               tmr_start = 1'b1;
               tmr_ch    = prio_ch_r;
               state_nxt = ST_PRIO;
            end else if (normal_go) begin
               tmr_start = 1'b1;
               tmr_ch    = mode3_r[`BIT_SCAN] ? scan_first : mode3_r[`FIXCH_MSB:`FIXCH_LSB];
               state_nxt = ST_NORM;
            end
         end
         ST_NORM: begin
            if (prio_go) begin
               // suspend: the normal conversion is dropped and redone later
               tmr_start = 1'b1;
               tmr_ch    = prio_ch_r;
               state_nxt = ST_PRIO;
            end else if (normal_go) begin
               // restart throws away the job in flight
               tmr_start = 1'b1;
               tmr_ch    = mode3_r[`BIT_SCAN] ? scan_first : mode3_r[`FIXCH_MSB:`FIXCH_LSB];
            end else if (tmr_done) begin
               res_wr = 1'b1;
               if (job_scan_r) begin
                  res_idx = {1'b0, cur_ch_r};
                  if (cur_ch_r == job_last_r) begin
                     eoc_set = 1'b1;
                     if (cont) begin
                        tmr_start = 1'b1;
                        tmr_ch    = job_first_r;
                     end else begin
                        state_nxt = ST_IDLE;
                     end
                  end else if (job_rep_r && !cont) begin
                     // repeat cleared mid-scan: stop after this channel
                     state_nxt = ST_IDLE;
                  end else begin
                     tmr_start = 1'b1;
                     tmr_ch    = cur_ch_r + 3'h1;
                  end
               end else if (job_rep_r) begin
                  res_idx = {1'b0, rep_idx_r};
                  eoc_set = (rep_idx_r == job_itm_r);
                  if (cont)
                     tmr_start = 1'b1;
                  else
                     state_nxt = ST_IDLE;
               end else begin
                  res_idx   = {1'b0, cur_ch_r};
                  eoc_set   = 1'b1;
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_PRIO: begin
            if (tmr_done) begin
               res_wr     = 1'b1;
               res_idx    = `PRIO_SLOT;
               hp_eoc_set = 1'b1;
               if (busy_r) begin
                  tmr_start = 1'b1;
                  tmr_ch    = cur_ch_r;
                  state_nxt = ST_NORM;
               end else begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer registers and flags
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_r             <= ST_IDLE;
         eoc_r               <= 1'b0;
         busy_r              <= 1'b0;
         hp_eoc_r            <= 1'b0;
         hp_busy_r           <= 1'b0;
         cur_ch_r            <= 3'h0;
         rep_idx_r           <= 3'h0;
         job_rep_r           <= 1'b0;
         job_scan_r          <= 1'b0;
         job_itm_r           <= 3'h0;
         job_first_r         <= 3'h0;
         job_last_r          <= 3'h0;
         normal_done_irq_o   <= 1'b0;
         priority_done_irq_o <= 1'b0;
      end else begin
         state_r             <= state_nxt;
         normal_done_irq_o   <= eoc_set;
         priority_done_irq_o <= hp_eoc_set;
         // set wins over read-clear
         hp_eoc_r  <= hp_eoc_set | (hp_eoc_r & ~rd_flags);
         hp_busy_r <= (state_nxt == ST_PRIO);
         if (normal_go && !(state_r == ST_PRIO) && !prio_go) begin
            // new normal job: latch mode, clear old status
            eoc_r       <= 1'b0;
            busy_r      <= 1'b1;
            job_rep_r   <= mode3_r[`BIT_REPEAT];
            job_scan_r  <= mode3_r[`BIT_SCAN];
            job_itm_r   <= mode3_r[`ITM_MSB:`ITM_LSB];
            job_first_r <= scan_first;
            job_last_r  <= scan_last;
            cur_ch_r    <= mode3_r[`BIT_SCAN] ? scan_first : mode3_r[`FIXCH_MSB:`FIXCH_LSB];
            rep_idx_r   <= 3'h0;
         end else begin
            eoc_r <= eoc_set | (eoc_r & ~rd_flags);
            if (state_r == ST_NORM && tmr_done && !prio_go) begin
               // repeat group wraps back to slot 0
               rep_idx_r <= (rep_idx_r == job_itm_r) ? 3'h0 : rep_idx_r + 3'h1;
               if (job_scan_r)
                  cur_ch_r <= (cur_ch_r == job_last_r) ? job_first_r : cur_ch_r + 3'h1;
               // busy stays high while repeat runs
               if (state_nxt == ST_IDLE)
                  busy_r <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // submodules
   conv_timer u_timer (
      .ref_clk_i  (ref_clk_i),
      .sys_rst_i  (sys_rst_i),
      .start_i    (tmr_start),
      .channel_i  (tmr_ch),
      .hold_i     (hold_eff),
      .adc_data_i (adc_data_i),
      .sample_o   (sample_o),
      .channel_o  (channel_o),
      .done_o     (tmr_done),
      .data_o     (tmr_data)
   );

   result_bank u_bank (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .wr_i      (res_wr),
      .wr_idx_i  (res_idx),
      .wr_data_i (tmr_data),
      .rd_idx_i  (rd_slot),
      .rd_data_o (bank_rd)
   );

endmodule

// file: dv/adc_core_model.sv
// converter core stand-in: answers with a channel-coded result
// assumes the sequencer holds channel_o until the window closes
`timescale 1ns/100ps
`include "adc_seq_defines.vh"
module adc_core_model (
   input  wire              sample_i,  // window open
   input  wire [2:0]        channel_i, // routed channel
   input  wire [8:0]        salt_i,    // tag from the bench
   output wire [`RES_W-1:0] data_o     // core result
);
   // inverted while sampling, so an early capture shows up
   assign data_o = sample_i ? ~{channel_i, salt_i} : {channel_i, salt_i};
endmodule

// file: dv/adc_conversion_sequencer_asserts.sv
// pin checker for the sequencer, bound to the top module
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module adc_seq_asserts (
   input wire        ref_clk_i,
   input wire        sys_rst_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire        sample_o,
   input wire        normal_done_irq_o,
   input wire        priority_done_irq_o
);
   reg [9:0] open_r; // cycles the window has stayed open
   ////////////////////////////////////////////////////////////
   // window length counter, cleared whenever the window is shut
   always @(posedge ref_clk_i) begin
      if (sys_rst_i || !sample_o)
         open_r <= 10'h000;
      else
         open_r <= open_r + 10'h001;
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   AST_SH_MIN: assert property ($fell(sample_o) |-> open_r >= 10'h00A)
      else $error("sample window too short");
   AST_NIRQ_GAP: assert property (normal_done_irq_o |=> (!normal_done_irq_o)[*8])
      else $error("normal irq too long or too close");
   AST_PIRQ_GAP: assert property (priority_done_irq_o |=> (!priority_done_irq_o)[*8])
      else $error("priority irq too long or too close");
   AST_IRQ_ONE: assert property (!(normal_done_irq_o && priority_done_irq_o))
      else $error("two completions at once");
   AST_CONV_PHASE: assert property ((normal_done_irq_o || priority_done_irq_o)
      |-> !$past(sample_o) && !$past(sample_o, 8))
      else $error("irq without a conversion phase");
   AST_READY: assert property (pready_o) // apb contract
      else $error("ready low");
   AST_ERR_PHASE: assert property (pslverr_o |-> psel_i && penable_i) // apb contract
      else $error("error outside access phase");
   AST_RDATA_IDLE: assert property (!(psel_i && penable_i && !pwrite_i) |-> prdata_o == 32'h0) // apb contract
      else $error("read data outside read");
endmodule
bind adc_conversion_sequencer adc_seq_asserts chk (.ref_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
   .prdata_o, .pready_o, .pslverr_o, .sample_o, .normal_done_irq_o, .priority_done_irq_o);

// file: dv/adc_conversion_sequencer_bench.sv
// self-checking bench for the converter sequencer
// assumes a zero-wait apb slave and the core stand-in
`timescale 1ns/100ps
`include "adc_seq_defines.vh"
`define CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin n_errors = n_errors + 1; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module adc_conversion_sequencer_bench;
   reg               ref_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, prev_s, err;
   reg  [7:0]        paddr_i;
   reg  [31:0]       pwdata_i, q;
   reg  [8:0]        salt;
   wire [31:0]       prdata_o;
   wire              pready_o, pslverr_o, sample_o, normal_done_irq_o, priority_done_irq_o;
   wire [2:0]        channel_o;
   wire [`RES_W-1:0] adc_data_i;
   integer           n_errors, n_tests, n_conv, run, last_len, cyc, base;
   adc_conversion_sequencer dut (.ref_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .adc_data_i, .sample_o, .channel_o, .normal_done_irq_o,
      .priority_done_irq_o);
   adc_core_model core (.sample_i(sample_o), .channel_i(channel_o), .salt_i(salt), .data_o(adc_data_i));
   // one clock for bus and converter: no gear change, no ratio to
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   ////////////////////////////////////////////////////////////
   // window starts and lengths seen at the pins, plus the hang guard
   always @(posedge ref_clk_i) begin
      prev_s <= sample_o;
      cyc <= cyc + 1;
      if (sample_o && !prev_s) n_conv <= n_conv + 1;
      run <= sample_o ? run + 1 : 0;
      if (!sample_o && prev_s) last_len <= run;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         stop_test;
      end
   end
   // apb master: setup, access held until ready, then release
   task apb(input wr, input [7:0] a, input [31:0] d);
      begin
         @(posedge ref_clk_i);
         psel_i <= 1'b1;
         pwrite_i <= wr;
         paddr_i <= a;
         pwdata_i <= d;
         @(posedge ref_clk_i);
         penable_i <= 1'b1;
         @(posedge ref_clk_i);
         while (pready_o !== 1'b1) @(posedge ref_clk_i);
         q = prdata_o;
         err = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         `CHK(q, e)
      end
   endtask
   task wait_irq(input pri);
      integer i;
      begin
         i = 0;
         while (((pri ? priority_done_irq_o : normal_done_irq_o) !== 1'b1) && i < 3000) begin
            @(posedge ref_clk_i);
            i = i + 1;
         end
         if (i >= 3000) begin
            n_errors = n_errors + 1;
            stop_test;
         end
      end
   endtask
   task t_reset;
      begin
         rd(`OFS_MODE_CONTROL_3, 32'h0);
         rd(`OFS_SAMPLE_HOLD, 32'hA);
         rd(8'h80, 32'h0);
         `CHK(err, 1'b1)
      end
   endtask
   // each channel lands in its own slot; flag cleared by reading
   task t_fixed;
      reg [7:0] ch;
      begin
         for (ch = 8'h00; ch < 8'h08; ch = ch + 8'h01) begin
            salt <= 9'h0C3 + {1'b0, ch};
            apb(1'b1, `OFS_MODE_CONTROL_3, {21'h0, ch[2:0], 8'h00});
            apb(1'b1, `OFS_START, 32'h1);
            wait_irq(1'b0);
            rd(`OFS_RESULT_BASE + {ch[5:0], 2'b00}, {20'h0, ch[2:0], salt});
            rd(`OFS_FLAG_STATUS, 32'h1);
            rd(`OFS_FLAG_STATUS, 32'h0);
         end
      end
   endtask
   // longest window, then a too-short setting that must clamp
   task t_hold;
      begin
         apb(1'b1, `OFS_SAMPLE_HOLD, 32'h140);
         apb(1'b1, `OFS_START, 32'h1);
         wait_irq(1'b0);
         `CHK(last_len, 320)
         apb(1'b1, `OFS_SAMPLE_HOLD, 32'h4);
         apb(1'b1, `OFS_START, 32'h1);
         wait_irq(1'b0);
         `CHK(last_len, 10)
      end
   endtask
   // eight per group with busy kept, then a stop mid-group
   task t_repeat;
      begin
         salt <= 9'h0A6;
         apb(1'b1, `OFS_MODE_CONTROL_3, 32'h471);
         base = n_conv;
         apb(1'b1, `OFS_START, 32'h1);
         wait_irq(1'b0);
         `CHK(n_conv - base, 8)
         rd(`OFS_FLAG_STATUS, 32'h3);
         rd(`OFS_RESULT_LAST, {20'h0, 3'h4, 9'h0A6});
         apb(1'b1, `OFS_MODE_CONTROL_3, 32'h470);
         repeat (30) @(posedge ref_clk_i);
         base = n_conv;
         rd(`OFS_FLAG_STATUS, 32'h0);
         repeat (30) @(posedge ref_clk_i);
         `CHK(n_conv, base)
      end
   endtask
   // width cut at the top slot, then a repeating two-channel scan
   task t_scan;
      begin
         salt <= 9'h1E1;
         apb(1'b1, `OFS_SCAN_CFG, 32'h75);
         apb(1'b1, `OFS_MODE_CONTROL_3, 32'h2);
         base = n_conv;
         apb(1'b1, `OFS_START, 32'h1);
         wait_irq(1'b0);
         `CHK(n_conv - base, 3)
         rd(`OFS_FLAG_STATUS, 32'h1);
         rd(`OFS_RESULT_BASE + 8'h14, {20'h0, 3'h5, 9'h1E1});
         rd(`OFS_RESULT_LAST, {20'h0, 3'h7, 9'h1E1});
         apb(1'b1, `OFS_SCAN_CFG, 32'h10);
         apb(1'b1, `OFS_MODE_CONTROL_3, 32'h3);
         apb(1'b1, `OFS_START, 32'h1);
         wait_irq(1'b0);
         rd(`OFS_FLAG_STATUS, 32'h3);
         rd(`OFS_RESULT_BASE + 8'h04, {20'h0, 3'h1, 9'h1E1});
         apb(1'b1, `OFS_MODE_CONTROL_3, 32'h2);
         repeat (30) @(posedge ref_clk_i);
         apb(1'b0, `OFS_FLAG_STATUS, 32'h0);
         `CHK(q[1], 1'b0)
      end
   endtask
   // priority cuts into a scan, which then finishes its channels
   // runs beside a single scan, so no repeat is stopped under it
   task t_prio;
      begin
         salt <= 9'h05A;
         apb(1'b1, `OFS_SCAN_CFG, 32'h20);
         apb(1'b1, `OFS_PRIO_CFG, 32'h3);
         apb(1'b1, `OFS_START, 32'h1);
         repeat (30) @(posedge ref_clk_i);
         apb(1'b1, `OFS_START, 32'h2);
         wait_irq(1'b1);
         rd(`OFS_PRIO_RESULT, {20'h0, 3'h3, 9'h05A});
         rd(`OFS_FLAG_STATUS, 32'h6);
         wait_irq(1'b0);
         rd(`OFS_FLAG_STATUS, 32'h1);
         rd(`OFS_RESULT_BASE + 8'h04, {20'h0, 3'h1, 9'h05A});
         rd(`OFS_RESULT_BASE + 8'h08, {20'h0, 3'h2, 9'h05A});
         // priority from idle: its busy shows, normal busy stays low
         apb(1'b1, `OFS_START, 32'h2);
         rd(`OFS_FLAG_STATUS, 32'h8);
         wait_irq(1'b1);
         rd(`OFS_FLAG_STATUS, 32'h4);
      end
   endtask
   task stop_test;
      begin
         $display("errors %0d of %0d checks", n_errors, n_tests);
         if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   initial begin
      {n_errors, n_tests, n_conv, run, last_len, cyc} = 0;
      {sys_rst_i, psel_i, penable_i, pwrite_i, prev_s} = 5'h10;
      {paddr_i, pwdata_i, salt} = 49'h0;
      repeat (8) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      t_reset;
      t_fixed;
      t_hold;
      t_repeat;
      t_scan;
      t_prio;
      stop_test;
   end
endmodule
